// file: rtl/dtwh_synth_core.sv
// Synthesizer core: step word selection, clamp, tuning word history
// What this block does
// - Accumulator adds 48-bit step every cycle
// - Wraparound keeps remainder above capacity
// - Add 16-bit phase offset to output
// - Hold 10-bit converter scale word
// - Free-run uses free-run step register
// - Closed loop uses loop filter word
// - Holdover uses averaged history word
// - Clamp step between 24-bit limits always
// - Clamp limits reset to full range
// - History interval counted in milliseconds
// - Store memoryless average at interval end
// - Strobe at interval end sets flag
// - Reference switch restarts; persistent keeps history
// - Clear history by bit or pin
// - No history waits T/2^K, or the full interval when K is zero
// - K schedules intermediate averages, first interval
// - K zero gives no intermediate averages
// - Later averages at full interval boundaries
// - Controller arbitrates profile update timing
// - Software forces holdover, free-run, reference
// - No history: fallback picks free-run/last
// - User holdover blocks automatic recovery
`timescale 1ns/100ps
`default_nettype none
module dtwh_synth_core
    import dtwh_pkg::*;
#(
    parameter int MS_COUNT = MS_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire dtwh_regbus_t regBus,
    input wire logic [47:0] filterWord,
    input wire logic filterValid,
    input wire logic refValid,
    input wire logic refSwitch,
    input wire logic pinHistClear,
    output logic [7:0] rdData,
    output logic [15:0] phaseOut,
    output logic [9:0] converterScaleWord,
    output logic historyStrobe,
    output logic historyUpdatedFlag,
    output logic [1:0] forcedRefSel,
    output logic forcedRefEn,
    output logic applyProfile,
    output logic [1:0] loopMode
);
    // Elaboration check: the tick counter needs at least one cycle
    if (MS_COUNT < 1) begin : g_bad_ms_count
        $error("MS_COUNT must be at least 1");
    end

    typedef struct packed {
        logic [15:0] scale;
        logic [47:0] freeRun;
        logic [47:0] clamp;
        logic [15:0] phase;
        logic [23:0] interval;
        logic [7:0] histMode;
        logic [7:0] loopCtl;
        logic [7:0] histMask;
        logic histFlag;
        logic [47:0] result;
        logic resultValid;
        logic firstInterval;
        logic [2:0] kLeft;
        logic [31:0] msCount;
        logic [23:0] msElapsed;
        logic [23:0] sumCount;
        logic [71:0] sum;
        logic [47:0] lastStep;
        dtwh_mode_t mode;
        logic strobe;
        logic applyProf;
        logic [7:0] rdData;
    } dtwh_state_t;

    dtwh_state_t st;
    dtwh_state_t next_st;
    logic [47:0] clampedStep;
    logic [47:0] rawStep;
    logic [15:0] accPhase;
    logic historyExists;
    logic clearReq;
    logic [23:0] dueAt;
    logic intervalEnd;
    logic [71:0] avg;

    // Clamp applied in every mode
    dtwh_step_clamp u_clamp (
        .stepIn(rawStep),
        .lowerLimit(st.clamp[23:0]),
        .upperLimit(st.clamp[47:24]),
        .stepOut(clampedStep)
    );

    dtwh_phase_accum u_accum (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .stepWord(clampedStep),
        .phaseOffset(st.phase),
        .accum(),
        .phaseOut(accPhase)
    );

    // Step word source by mode
    always_comb begin
        historyExists = st.resultValid;
        case (st.mode)
            DTWH_FREERUN: rawStep = st.freeRun;
            DTWH_CLOSED: rawStep = filterWord;
            DTWH_HOLDOVER: begin
                if (historyExists) begin
                    rawStep = st.result;
                end else if (st.histMode[HM_FALLBACK_BIT]) begin
                    rawStep = st.lastStep;
                end else begin
                    rawStep = st.freeRun;
                end
            end
            default: rawStep = st.freeRun;
        endcase
    end

    // Clear sources and interval schedule
    always_comb begin
        clearReq = pinHistClear;
        if (regBus.wrEn && regBus.addr == ADDR_HIST_CLEAR &&
            regBus.wrData[HC_CLEAR_BIT]) begin
            clearReq = 1'b1;
        end
        if (refSwitch && !st.histMode[HM_PERSIST_BIT]) begin
            clearReq = 1'b1;
        end
        // First interval: fractions T/2^k; later only full T
        if (st.firstInterval && st.kLeft != 3'h0) begin
            dueAt = st.interval >> st.kLeft;
        end else begin
            dueAt = st.interval;
        end
        intervalEnd = (st.msCount == MS_COUNT - 1) &&
                      (st.msElapsed + 24'h000001 >= dueAt);
        avg = (st.sumCount == 24'h000000) ? 72'h0 : st.sum / st.sumCount;
    end

    // Next state
    always_comb begin
        next_st = st;
        next_st.strobe = 1'b0;
        next_st.applyProf = 1'b0;
        next_st.lastStep = clampedStep;
        // Millisecond tick
        if (st.msCount == MS_COUNT - 1) begin
            next_st.msCount = '0;
            next_st.msElapsed = st.msElapsed + 24'h000001;
        end else begin
            next_st.msCount = st.msCount + 32'h1;
        end
        // Running sum over the interval, closed loop only
        if (st.mode == DTWH_CLOSED && filterValid) begin
            next_st.sum = st.sum + {24'h000000, filterWord};
            next_st.sumCount = st.sumCount + 24'h000001;
        end
        if (intervalEnd) begin
            // Empty interval (holdover) keeps the earlier history
            if (st.sumCount != 24'h000000) begin
                next_st.result = avg[47:0];
                next_st.resultValid = 1'b1;
            end
            next_st.strobe = 1'b1;
            next_st.sum = '0;
            next_st.sumCount = '0;
            if (st.firstInterval && st.kLeft != 3'h0) begin
                next_st.kLeft = st.kLeft - 3'h1;
            end else begin
                next_st.firstInterval = 1'b0;
                next_st.msElapsed = '0;
            end
        end
        // Restart accumulation on reference switch
        if (refSwitch) begin
            next_st.sum = '0;
            next_st.sumCount = '0;
            next_st.msCount = '0;
            next_st.msElapsed = '0;
            next_st.applyProf = 1'b1;
        end
        if (clearReq) begin
            next_st.resultValid = 1'b0;
            next_st.firstInterval = 1'b1;
            next_st.kLeft = st.histMode[2:0];
            next_st.sum = '0;
            next_st.sumCount = '0;
            next_st.msCount = '0;
            next_st.msElapsed = '0;
        end
        // Loop mode selection
        if (st.loopCtl[LM_FREERUN_BIT]) begin
            next_st.mode = DTWH_FREERUN;
        end else if (st.loopCtl[LM_HOLDOVER_BIT] || !refValid) begin
            next_st.mode = DTWH_HOLDOVER;
        end else begin
            next_st.mode = DTWH_CLOSED;
        end
        if (next_st.mode != st.mode) begin
            next_st.applyProf = 1'b1;
        end
        // Register writes
        if (regBus.wrEn) begin
            case (regBus.addr)
                ADDR_SCALE_LO: next_st.scale[7:0] = regBus.wrData;
                ADDR_SCALE_HI: next_st.scale[15:8] = regBus.wrData;
                ADDR_PHASE: next_st.phase[7:0] = regBus.wrData;
                ADDR_PHASE + 12'h1: next_st.phase[15:8] = regBus.wrData;
                ADDR_HIST_MODE: next_st.histMode = regBus.wrData;
                ADDR_LOOP_MODE: next_st.loopCtl = regBus.wrData;
                ADDR_HIST_CLEAR: next_st.histMask = regBus.wrData;
                default: begin
                    for (int i = 0; i < 6; i++) begin
                        if (regBus.addr == ADDR_FREE_RUN + 12'(i)) begin
                            next_st.freeRun[8*i +: 8] = regBus.wrData;
                        end
                        if (regBus.addr == ADDR_CLAMP + 12'(i)) begin
                            next_st.clamp[8*i +: 8] = regBus.wrData;
                        end
                    end
                    for (int i = 0; i < 3; i++) begin
                        if (regBus.addr == ADDR_INTERVAL + 12'(i)) begin
                            next_st.interval[8*i +: 8] = regBus.wrData;
                        end
                    end
                end
            endcase
        end
        // Sticky flag: set wins over clear
        if (regBus.wrEn && regBus.addr == ADDR_HIST_RESULT + 12'h6) begin
            next_st.histFlag = 1'b0;
        end
        if (st.strobe && st.histMask[0]) begin
            next_st.histFlag = 1'b1;
        end
        // Register reads, unmapped reads zero
        next_st.rdData = 8'h00;
        if (regBus.rdEn) begin
            for (int i = 0; i < 6; i++) begin
                if (regBus.addr == ADDR_HIST_RESULT + 12'(i)) begin
                    next_st.rdData = st.result[8*i +: 8];
                end
                if (regBus.addr == ADDR_FREE_RUN + 12'(i)) begin
                    next_st.rdData = st.freeRun[8*i +: 8];
                end
                if (regBus.addr == ADDR_CLAMP + 12'(i)) begin
                    next_st.rdData = st.clamp[8*i +: 8];
                end
            end
            for (int i = 0; i < 3; i++) begin
                if (regBus.addr == ADDR_INTERVAL + 12'(i)) begin
                    next_st.rdData = st.interval[8*i +: 8];
                end
            end
            case (regBus.addr)
                ADDR_SCALE_LO: next_st.rdData = st.scale[7:0];
                ADDR_SCALE_HI: next_st.rdData = st.scale[15:8];
                ADDR_PHASE: next_st.rdData = st.phase[7:0];
                ADDR_PHASE + 12'h1: next_st.rdData = st.phase[15:8];
                ADDR_HIST_MODE: next_st.rdData = st.histMode;
                ADDR_LOOP_MODE: next_st.rdData = st.loopCtl;
                ADDR_HIST_CLEAR: next_st.rdData = st.histMask;
                ADDR_HIST_RESULT + 12'h6:
                    next_st.rdData = {5'h00, st.resultValid, 1'b0,
                                      st.histFlag};
                default: ;
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st <= '0;
            st.clamp <= {CLAMP_UPPER_RESET, CLAMP_LOWER_RESET};
            st.interval <= INTERVAL_RESET;
            st.firstInterval <= 1'b1;
            st.mode <= DTWH_FREERUN;
        end else begin
            st <= next_st;
        end
    end

    // Output flops
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            phaseOut <= '0;
        end else begin
            phaseOut <= accPhase;
        end
    end
    assign rdData = st.rdData;
    assign converterScaleWord = st.scale[9:0];
    assign historyStrobe = st.strobe;
    assign historyUpdatedFlag = st.histFlag;
    assign forcedRefSel = st.loopCtl[1:0];
    assign forcedRefEn = st.loopCtl[2];
    assign applyProfile = st.applyProf;
    assign loopMode = st.mode;
endmodule : dtwh_synth_core
`default_nettype wire

// file: rtl/dtwh_pkg.sv
// Package of constants and types for the tuning word history synthesizer
package dtwh_pkg;
    // Register byte addresses
    localparam logic [11:0] ADDR_SCALE_LO = 12'h213;
    localparam logic [11:0] ADDR_SCALE_HI = 12'h214;
    localparam logic [11:0] ADDR_FREE_RUN = 12'h300;
    localparam logic [11:0] ADDR_CLAMP = 12'h307;
    localparam logic [11:0] ADDR_PHASE = 12'h30D;
    localparam logic [11:0] ADDR_INTERVAL = 12'h318;
    localparam logic [11:0] ADDR_HIST_MODE = 12'h31B;
    localparam logic [11:0] ADDR_LOOP_MODE = 12'hA01;
    localparam logic [11:0] ADDR_HIST_CLEAR = 12'hA03;
    localparam logic [11:0] ADDR_HIST_RESULT = 12'hD14;
    // Field positions
    localparam int HM_PERSIST_BIT = 3;
    localparam int HM_FALLBACK_BIT = 4;
    localparam int LM_HOLDOVER_BIT = 6;
    localparam int LM_FREERUN_BIT = 5;
    localparam int HC_CLEAR_BIT = 2;
    // Reset values
    localparam logic [23:0] CLAMP_LOWER_RESET = 24'h000000;
    localparam logic [23:0] CLAMP_UPPER_RESET = 24'hFFFFFF;
    localparam logic [23:0] INTERVAL_RESET = 24'h000001;
    // Millisecond timing at 125 MHz
    localparam int SYS_CLK_MHZ = 125;
    localparam int MS_TIME_US = 1000;
    localparam int MS_CYCLES = MS_TIME_US * SYS_CLK_MHZ;

    typedef enum logic [1:0] {
        DTWH_CLOSED,
        DTWH_HOLDOVER,
        DTWH_FREERUN
    } dtwh_mode_t;

    // Register read/write port
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [11:0] addr;
        logic [7:0] wrData;
    } dtwh_regbus_t;
endpackage : dtwh_pkg

// file: rtl/dtwh_step_clamp.sv
// Clamp of a 48-bit step word between two 24-bit limits
`timescale 1ns/100ps
`default_nettype none
module dtwh_step_clamp (
    input wire logic [47:0] stepIn,
    input wire logic [23:0] lowerLimit,
    input wire logic [23:0] upperLimit,
    output logic [47:0] stepOut
);
    logic [47:0] lowerWord;
    logic [47:0] upperWord;
    // Limit N scales to fs*N/2^24, i.e. N in the top 24 bits
    always_comb begin
        lowerWord = {lowerLimit, 24'h000000};
        upperWord = (upperLimit == 24'hFFFFFF) ? 48'hFFFFFFFFFFFF
                                               : {upperLimit, 24'h000000};
        if (stepIn < lowerWord) begin
            stepOut = lowerWord;
        end else if (stepIn > upperWord) begin
            stepOut = upperWord;
        end else begin
            stepOut = stepIn;
        end
    end
endmodule : dtwh_step_clamp
`default_nettype wire

// file: rtl/dtwh_phase_accum.sv
// Modulo 2^48 phase accumulator with phase offset
`timescale 1ns/100ps
`default_nettype none
module dtwh_phase_accum
    import dtwh_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [47:0] stepWord,
    input wire logic [15:0] phaseOffset,
    output logic [47:0] accum,
    output logic [15:0] phaseOut
);
    typedef struct packed {
        logic [47:0] accum;
        logic [15:0] phase;
    } dtwh_acc_state_t;
    dtwh_acc_state_t st;
    dtwh_acc_state_t next_st;
    // Add step; wrap keeps the excess
    always_comb begin
        next_st = st;
        next_st.accum = st.accum + stepWord;
        next_st.phase = st.accum[47:32] + phaseOffset;
    end
    // State register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign accum = st.accum;
    assign phaseOut = st.phase;
endmodule : dtwh_phase_accum
`default_nettype wire

// file: sim/dtwh_synth_checker.sv
// Concurrent checks on the synthesizer core ports
`timescale 1ns/100ps
`default_nettype none
module dtwh_synth_checker
    import dtwh_pkg::*;
#(
    parameter int MS_COUNT = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire dtwh_regbus_t regBus,
    input wire logic refValid,
    input wire logic refSwitch,
    input wire logic [7:0] rdData,
    input wire logic [9:0] converterScaleWord,
    input wire logic historyStrobe,
    input wire logic historyUpdatedFlag,
    input wire logic forcedRefEn,
    input wire logic applyProfile,
    input wire logic [1:0] loopMode
);
    localparam int FIRST_LO = MS_COUNT - 3;
    localparam int FIRST_HI = MS_COUNT;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Quiet start and missing reference spans
    sequence quiet_s;
        !historyStrobe [*3];
    endsequence
    sequence noref_s;
        !refValid [*3];
    endsequence
    // One assertion per guarded behaviour
    first_strobe_a: assert property (
        $rose(rst_n) |-> quiet_s ##[FIRST_LO:FIRST_HI] historyStrobe)
        else $error("first history strobe out of place");
    strobe_pulse_a: assert property (
        historyStrobe |=> !historyStrobe)
        else $error("history strobe longer than one cycle");
    flag_cause_a: assert property (
        $rose(historyUpdatedFlag) |-> historyStrobe || $past(historyStrobe))
        else $error("history flag set without strobe");
    scale_cause_a: assert property (
        !$stable(converterScaleWord) |->
            $past(regBus.wrEn) || $past(regBus.wrEn, 2))
        else $error("scale word changed without a write");
    forced_cause_a: assert property (
        !$stable(forcedRefEn) |-> $past(regBus.wrEn) || $past(regBus.wrEn, 2))
        else $error("forced reference changed without a write");
    mode_profile_a: assert property (
        !$stable(loopMode) |-> applyProfile || $past(applyProfile))
        else $error("mode change without profile pulse");
    switch_profile_a: assert property (
        refSwitch |=> applyProfile)
        else $error("reference switch without profile pulse");
    rd_idle_a: assert property (
        !regBus.rdEn |=> rdData == 8'h00)
        else $error("read data present without a read");
    ref_loss_a: assert property (
        noref_s |-> loopMode != DTWH_CLOSED)
        else $error("closed loop kept without reference");
endmodule // dtwh_synth_checker
bind dtwh_synth_core dtwh_synth_checker #(.MS_COUNT(MS_COUNT)) i_checker (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .regBus(regBus),
    .refValid(refValid),
    .refSwitch(refSwitch),
    .rdData(rdData),
    .converterScaleWord(converterScaleWord),
    .historyStrobe(historyStrobe),
    .historyUpdatedFlag(historyUpdatedFlag),
    .forcedRefEn(forcedRefEn),
    .applyProfile(applyProfile),
    .loopMode(loopMode)
);
`default_nettype wire

// file: sim/dtwh_dac_model.sv
// Behavioural model of the converter fed by the core
`timescale 1ns/100ps
`default_nettype none
module dtwh_dac_model (
    input wire logic sys_clk,
    input wire logic [15:0] phaseSample,
    input wire logic [9:0] scaleCode,
    output logic [15:0] phaseStep,
    output logic [15:0] fullScale
);
    logic [15:0] prevPhase;
    // Previous phase sample
    always_ff @(posedge sys_clk) begin
        prevPhase <= phaseSample;
    end
    // Phase advance per sample, one full turn is 2^16
    assign phaseStep = phaseSample - prevPhase;
    // Full scale current in steps of 7.5 uA
    assign fullScale = 16'h0480 + 16'h0003 * 16'(scaleCode);
endmodule // dtwh_dac_model
`default_nettype wire

// file: sim/dtwh_synth_core_tb_top.sv
// Self-checking testbench of the synthesizer core
`timescale 1ns/100ps
`default_nettype none
module dtwh_synth_core_tb_top
    import dtwh_pkg::*;
();
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    dtwh_regbus_t bus = '0;
    logic [47:0] filterWord = 48'h0;
    logic filterValid = 1'b0, refValid = 1'b0;
    logic refSwitch = 1'b0, pinHistClear = 1'b0;
    logic [7:0] rdData, b;
    logic [15:0] phaseOut, phaseStep, fullScale, p;
    logic [9:0] scaleWord;
    logic strobe, flag, applyProfile, forcedRefEn;
    logic [1:0] forcedRefSel, loopMode;
    logic [47:0] v;
    int n_fail = 0, n_compared = 0, n;
    // Clock of 8 ns
    always #4 sys_clk = ~sys_clk;
    dtwh_synth_core #(.MS_COUNT(4)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .regBus(bus), .filterWord(filterWord), .filterValid(filterValid),
        .refValid(refValid), .refSwitch(refSwitch),
        .pinHistClear(pinHistClear), .rdData(rdData), .phaseOut(phaseOut),
        .converterScaleWord(scaleWord), .historyStrobe(strobe),
        .historyUpdatedFlag(flag), .forcedRefSel(forcedRefSel),
        .forcedRefEn(forcedRefEn), .applyProfile(applyProfile),
        .loopMode(loopMode));
    dtwh_dac_model i_dac (.sys_clk(sys_clk), .phaseSample(phaseOut),
        .scaleCode(scaleWord), .phaseStep(phaseStep), .fullScale(fullScale));
    task automatic end_of_test();
        if (n_fail == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus <= '{1'b1, 1'b0, a, d};
        @(posedge sys_clk);
        bus <= '0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        bus <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge sys_clk);
        bus <= '0;
        @(negedge sys_clk);
        d = rdData;
    endtask
    task automatic wr48(input logic [11:0] a, input logic [47:0] w);
        for (int i = 0; i < 6; i++) wr(a + 12'(i), w[8*i+:8]);
    endtask
    task automatic rd48(input logic [11:0] a, output logic [47:0] w);
        logic [7:0] d;
        for (int i = 0; i < 6; i++) begin
            rd(a + 12'(i), d);
            w[8*i+:8] = d;
        end
    endtask
    task automatic stepchk(input logic [15:0] e);
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(48'(phaseStep), 48'(e));
    endtask
    task automatic wstb(output int c);
        c = 0;
        do begin
            @(negedge sys_clk);
            c++;
        end while (strobe !== 1'b1 && c < 200);
    endtask
    // Scenarios
    task automatic t_reset();
        rd48(ADDR_CLAMP, v);
        chk(v, 48'hFFFFFF_000000);
        rd(ADDR_INTERVAL, b);
        chk(48'(b), 48'h01);
    endtask
    task automatic t_freerun();
        wr(ADDR_LOOP_MODE, 8'h27);
        wr48(ADDR_FREE_RUN, 48'h0001_0000_0000);
        stepchk(16'h0001);
        chk(48'({loopMode, forcedRefEn, forcedRefSel}), 48'h17);
        wr48(ADDR_FREE_RUN, 48'hFFFF_0000_0000);
        stepchk(16'hFFFF);
    endtask
    task automatic t_clamp();
        wr48(ADDR_FREE_RUN, 48'h0800_0000_0000);
        wr48(ADDR_CLAMP, 48'h010000_000000);
        stepchk(16'h0100);
        wr48(ADDR_FREE_RUN, 48'h0);
        wr48(ADDR_CLAMP, 48'hFFFFFF_020000);
        stepchk(16'h0200);
        wr48(ADDR_CLAMP, 48'hFFFFFF_000000);
        stepchk(16'h0000);
    endtask
    task automatic t_offset_scale();
        p = phaseOut;
        wr(ADDR_PHASE + 12'h1, 8'h40);
        wr(ADDR_SCALE_LO, 8'h34);
        wr(ADDR_SCALE_HI, 8'h02);
        repeat (3) @(negedge sys_clk);
        chk(48'(phaseOut), 48'(p + 16'h4000));
        chk(48'(fullScale), 48'h0B1C);
    endtask
    task automatic t_hist();
        wr(ADDR_LOOP_MODE, 8'h00);
        @(posedge sys_clk);
        refValid <= 1'b1;
        filterValid <= 1'b1;
        filterWord <= 48'h0003_0000_0000;
        stepchk(16'h0003);
        wr(ADDR_HIST_CLEAR, 8'h05);
        wstb(n);
        wstb(n);
        rd48(ADDR_HIST_RESULT, v);
        chk(v, 48'h0003_0000_0000);
        chk(48'(flag), 48'h1);
        // Drop reference first; new filter word only once in holdover
        @(posedge sys_clk);
        refValid <= 1'b0;
        @(posedge sys_clk);
        filterWord <= 48'h0005_0000_0000;
        stepchk(16'h0003);
        wr(ADDR_LOOP_MODE, 8'h40);
        @(posedge sys_clk);
        refValid <= 1'b1;
        stepchk(16'h0003);
        chk(48'(loopMode), 48'(DTWH_HOLDOVER));
    endtask
    task automatic t_clear();
        wr48(ADDR_FREE_RUN, 48'h0007_0000_0000);
        @(posedge sys_clk);
        pinHistClear <= 1'b1;
        @(posedge sys_clk);
        pinHistClear <= 1'b0;
        rd(12'hD1A, b);
        chk(48'(b[2]), 48'h0);
        stepchk(16'h0007);
        // Fallback set: the last instantaneous step is held
        wr(ADDR_HIST_MODE, 8'h10);
        wr48(ADDR_FREE_RUN, 48'h0009_0000_0000);
        stepchk(16'h0007);
    endtask
    task automatic t_switch(input logic [7:0] m, input logic e);
        wr(ADDR_LOOP_MODE, 8'h00);
        wr(ADDR_INTERVAL, 8'h04);
        wstb(n);
        wstb(n);
        wr(ADDR_HIST_MODE, m);
        @(posedge sys_clk);
        refSwitch <= 1'b1;
        @(posedge sys_clk);
        refSwitch <= 1'b0;
        rd(12'hD1A, b);
        chk(48'(b[2]), 48'(e));
    endtask
    task automatic t_gaps(input logic [7:0] k, input int g0, g1, g2, g3);
        wr(ADDR_HIST_MODE, k);
        wr(ADDR_HIST_CLEAR, 8'h05);
        // Skip a strobe that may coincide with the clear itself
        repeat (2) @(negedge sys_clk);
        wstb(n);
        chk(48'(n + 1), 48'(g0));
        wstb(n);
        chk(48'(n), 48'(g1));
        wstb(n);
        chk(48'(n), 48'(g2));
        wstb(n);
        chk(48'(n), 48'(g3));
    endtask
    // Watchdog, about forty times the expected run
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        end_of_test();
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_freerun();
        t_clamp();
        t_offset_scale();
        t_hist();
        t_clear();
        t_switch(8'h08, 1'b1);
        t_switch(8'h00, 1'b0);
        t_gaps(8'h00, 16, 16, 16, 16);
        t_gaps(8'h01, 8, 8, 16, 16);
        t_gaps(8'h02, 4, 4, 8, 16);
        end_of_test();
    end
endmodule // dtwh_synth_core_tb_top
`default_nettype wire
